// *** rtl/lprpa_pkg.sv ***
// lprpa_pkg: command encodings, bank states and timing counts of the refresh/power block
// assumes a 25 MHz command clock
package lprpa_pkg;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WRITE_RECOV_NS  = 15;
  localparam int WRITE_RECOV_CYC = (WRITE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_PERIOD_NS  = 30;
  localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_TIME_NS  = 110;
  localparam int REFRESH_CYCLE_TIME_CYC =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_LEN   = 4;
  localparam int NUM_BANKS   = 4;
  localparam int ROW_BITS    = 14;
  localparam int AP_BIT      = 10;
  localparam int CNT_W       = 4;
  localparam logic [ROW_BITS-1:0] ROW_CNT_RST = 14'h0000;
  // command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_ACTIVE  = 4'h3;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_PRECH   = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE    = 4'h0;
  typedef enum logic [1:0] {LPRPA_BK_IDLE, LPRPA_BK_ACTIVE, LPRPA_BK_RECOV, LPRPA_BK_PRECH}
    lprpa_bank_t;
  typedef enum logic [2:0] {LPRPA_PW_INIT, LPRPA_PW_NORMAL, LPRPA_PW_REFRESH,
    LPRPA_PW_SELF, LPRPA_PW_DOWN} lprpa_power_t;
endpackage

// *** rtl/lprpa_bank_if.sv ***
// lprpa_bank_if: command strobes from the decoder to each bank timer and bank states back
// assumes one clock shared by both ends
interface lprpa_bank_if;
  logic                     act;
  logic                     wr_ap;
  logic                     prech;
  logic                     force_idle;
  lprpa_pkg::lprpa_bank_t   state;
  modport ctrl (output act, output wr_ap, output prech, output force_idle, input state);
  modport bank (input act, input wr_ap, input prech, input force_idle, output state);
endinterface

// *** rtl/lprpa_bank.sv ***
// lprpa_bank: one bank's state with write recovery and internal precharge timers
// assumes strobes come from the same clock
module lprpa_bank (
  input  wire logic   clk,
  input  wire logic   rst_n,
  lprpa_bank_if.bank  bif
);
  typedef logic [lprpa_pkg::CNT_W-1:0] lprpa_bcnt_t;
  lprpa_pkg::lprpa_bank_t      st_q, st_d;
  lprpa_bcnt_t                 cnt_q, cnt_d;

  always_comb
  begin
    st_d  = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 4'h1 : cnt_q;
    case (st_q)
      lprpa_pkg::LPRPA_BK_IDLE:
        if (bif.act)
        begin
          st_d = lprpa_pkg::LPRPA_BK_ACTIVE;
        end
      lprpa_pkg::LPRPA_BK_ACTIVE:
        if (bif.wr_ap)
        begin
          st_d  = lprpa_pkg::LPRPA_BK_RECOV;
          cnt_d = lprpa_bcnt_t'(lprpa_pkg::BURST_LEN / 2 + lprpa_pkg::WRITE_RECOV_CYC);
        end
        else if (bif.prech)
        begin
          st_d  = lprpa_pkg::LPRPA_BK_PRECH;
          cnt_d = lprpa_bcnt_t'(lprpa_pkg::PRECHARGE_PERIOD_CYC);
        end
      lprpa_pkg::LPRPA_BK_RECOV:
        if (cnt_q <= 4'h1)
        begin
          st_d  = lprpa_pkg::LPRPA_BK_PRECH;
          cnt_d = lprpa_bcnt_t'(lprpa_pkg::PRECHARGE_PERIOD_CYC);
        end
      lprpa_pkg::LPRPA_BK_PRECH:
        if (cnt_q <= 4'h1)
        begin
          st_d = lprpa_pkg::LPRPA_BK_IDLE;
        end
      default:
        st_d = lprpa_pkg::LPRPA_BK_IDLE;
    endcase
    if (bif.force_idle)
    begin
      st_d  = lprpa_pkg::LPRPA_BK_IDLE;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q  <= lprpa_pkg::LPRPA_BK_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign bif.state = st_q;
endmodule // lprpa_bank

// *** rtl/lprpa_core.sv ***
// lprpa_core: command decode, auto/self refresh, power-down and mode capture of the die
// assumes pins are sampled by two flops; the controller keeps its own timing rules
// Notes on behaviour
// - write with address bit ten high auto-precharges the addressed bank
// - internal precharge starts only after write recovery past last data
// - auto refresh: cs, ras, cas low with cke and we high
// - refresh rows come from an internal counter, address pins ignored
// - after refresh every bank is idle
// - self refresh: cs, ras, cas, cke low with we high
// - cke low holds self refresh; internal clock gated one cycle after entry
// - cke low enters power-down, high exits; receivers except clock and cke gated
// - both mode registers must be programmed with all banks idle
module lprpa_core #(
  parameter int NUM_BANKS = lprpa_pkg::NUM_BANKS,
  parameter int ROW_BITS  = lprpa_pkg::ROW_BITS
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  input  wire logic                  CKE,
  input  wire logic                  CS_N,
  input  wire logic                  RAS_N,
  input  wire logic                  CAS_N,
  input  wire logic                  WE_N,
  input  wire logic [1:0]            BA,
  input  wire logic [ROW_BITS-1:0]   ADDR,
  output logic [NUM_BANKS*2-1:0]     BANK_STATE,
  output logic [ROW_BITS-1:0]        REFRESH_ROW,
  output logic                       REFRESHING,
  output logic                       SELF_REFRESH,
  output logic                       POWERED_DOWN,
  output logic                       INT_CLK_EN,
  output logic                       MODE_READY,
  output logic [ROW_BITS-1:0]        MODE_VALUE,
  output logic [ROW_BITS-1:0]        EXT_MODE_VALUE
);
  typedef logic [lprpa_pkg::CNT_W-1:0] lprpa_cnt_t;

  // two-flop input synchronisers
  logic [5+2+ROW_BITS-1:0] s1_q, s2_q;
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      s1_q <= '1;
      s2_q <= '1;
    end
    else
    begin
      s1_q <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
      s2_q <= s1_q;
    end
  end

  logic                cke_s;
  logic [3:0]          cmd;
  logic [1:0]          ba_s;
  logic [ROW_BITS-1:0] addr_s;
  assign cke_s  = s2_q[ROW_BITS+6];
  assign cmd    = s2_q[ROW_BITS+5:ROW_BITS+2];
  assign ba_s   = s2_q[ROW_BITS+1:ROW_BITS];
  assign addr_s = s2_q[ROW_BITS-1:0];

  lprpa_pkg::lprpa_power_t pw_q, pw_d;
  logic                    cke_prev_q, cke_prev_d;
  lprpa_cnt_t              rcnt_q, rcnt_d;
  logic [ROW_BITS-1:0]     row_q, row_d, mode_q, mode_d, emode_q, emode_d;
  logic [1:0]              modes_q, modes_d;
  logic                    clk_en_q, clk_en_d;
  logic                    all_idle;
  logic                    live;
  logic                    refresh_done;
  logic [NUM_BANKS-1:0]    b_act, b_wrap, b_pre;
  lprpa_pkg::lprpa_bank_t  b_state [NUM_BANKS];

  // receivers gated while powered down or in self refresh
  assign live = cke_s && cke_prev_q &&
                (pw_q == lprpa_pkg::LPRPA_PW_NORMAL || pw_q == lprpa_pkg::LPRPA_PW_INIT);

  always_comb
  begin
    all_idle = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      if (b_state[i] != lprpa_pkg::LPRPA_BK_IDLE)
      begin
        all_idle = 1'b0;
      end
    end
  end

  assign refresh_done = (pw_q == lprpa_pkg::LPRPA_PW_REFRESH) && (rcnt_q <= 4'h1);

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++)
    begin : g_bank
      lprpa_bank_if bif ();
      logic sel;
      assign sel       = (ba_s == 2'(g));
      assign b_act[g]  = live && cmd == lprpa_pkg::CMD_ACTIVE && sel;
      assign b_wrap[g] = live && cmd == lprpa_pkg::CMD_WRITE && sel && addr_s[lprpa_pkg::AP_BIT];
      assign b_pre[g]  = live && cmd == lprpa_pkg::CMD_PRECH && (sel || addr_s[lprpa_pkg::AP_BIT]);
      assign bif.act        = b_act[g];
      assign bif.wr_ap      = b_wrap[g];
      assign bif.prech      = b_pre[g];
      assign bif.force_idle = refresh_done;
      assign b_state[g]     = bif.state;
      lprpa_bank u_bank (
        .clk   (MCLK),
        .rst_n (RST_N),
        .bif   (bif)
      );
    end
  endgenerate

  always_comb
  begin
    pw_d       = pw_q;
    cke_prev_d = cke_s;
    rcnt_d     = (rcnt_q != '0) ? rcnt_q - 4'h1 : rcnt_q;
    row_d      = row_q;
    mode_d     = mode_q;
    emode_d    = emode_q;
    modes_d    = modes_q;
    clk_en_d   = clk_en_q;
    case (pw_q)
      lprpa_pkg::LPRPA_PW_INIT, lprpa_pkg::LPRPA_PW_NORMAL:
      begin
        clk_en_d = 1'b1;
        if (cke_prev_q && cmd == lprpa_pkg::CMD_REFRESH && !cke_s)
        begin
          pw_d = lprpa_pkg::LPRPA_PW_SELF;
        end
        else if (cke_prev_q && !cke_s)
        begin
          pw_d = lprpa_pkg::LPRPA_PW_DOWN;
        end
        else if (live && cmd == lprpa_pkg::CMD_REFRESH)
        begin
          pw_d   = lprpa_pkg::LPRPA_PW_REFRESH;
          rcnt_d = lprpa_cnt_t'(lprpa_pkg::REFRESH_CYCLE_TIME_CYC);
        end
        else if (live && cmd == lprpa_pkg::CMD_MODE && all_idle)
        begin
          if (ba_s[1])
          begin
            emode_d    = addr_s;
            modes_d[1] = 1'b1;
          end
          else
          begin
            mode_d     = addr_s;
            modes_d[0] = 1'b1;
          end
        end
        if (modes_q == 2'h3)
        begin
          pw_d = (pw_d == lprpa_pkg::LPRPA_PW_INIT) ? lprpa_pkg::LPRPA_PW_NORMAL : pw_d;
        end
      end
      lprpa_pkg::LPRPA_PW_REFRESH:
        if (rcnt_q <= 4'h1)
        begin
          row_d = row_q + 14'h0001;
          pw_d  = (modes_q == 2'h3) ? lprpa_pkg::LPRPA_PW_NORMAL : lprpa_pkg::LPRPA_PW_INIT;
        end
      lprpa_pkg::LPRPA_PW_SELF:
      begin
        clk_en_d = 1'b0;
        if (cke_s)
        begin
          pw_d     = (modes_q == 2'h3) ? lprpa_pkg::LPRPA_PW_NORMAL : lprpa_pkg::LPRPA_PW_INIT;
          clk_en_d = 1'b1;
        end
        else if (!clk_en_q)
        begin
          row_d = row_q + 14'h0001;
        end
      end
      lprpa_pkg::LPRPA_PW_DOWN:
        if (cke_s)
        begin
          pw_d = (modes_q == 2'h3) ? lprpa_pkg::LPRPA_PW_NORMAL : lprpa_pkg::LPRPA_PW_INIT;
        end
      default:
        pw_d = lprpa_pkg::LPRPA_PW_INIT;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      pw_q       <= lprpa_pkg::LPRPA_PW_INIT;
      cke_prev_q <= 1'b1;
      rcnt_q     <= '0;
      row_q      <= lprpa_pkg::ROW_CNT_RST;
      mode_q     <= '0;
      emode_q    <= '0;
      modes_q    <= 2'h0;
      clk_en_q   <= 1'b1;
    end
    else
    begin
      pw_q       <= pw_d;
      cke_prev_q <= cke_prev_d;
      rcnt_q     <= rcnt_d;
      row_q      <= row_d;
      mode_q     <= mode_d;
      emode_q    <= emode_d;
      modes_q    <= modes_d;
      clk_en_q   <= clk_en_d;
    end
  end

  // registered outputs
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      BANK_STATE     <= '0;
      REFRESH_ROW    <= '0;
      REFRESHING     <= 1'b0;
      SELF_REFRESH   <= 1'b0;
      POWERED_DOWN   <= 1'b0;
      INT_CLK_EN     <= 1'b1;
      MODE_READY     <= 1'b0;
      MODE_VALUE     <= '0;
      EXT_MODE_VALUE <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_BANKS; i++)
      begin
        BANK_STATE[i*2 +: 2] <= b_state[i];
      end
      REFRESH_ROW    <= row_q;
      REFRESHING     <= (pw_q == lprpa_pkg::LPRPA_PW_REFRESH);
      SELF_REFRESH   <= (pw_q == lprpa_pkg::LPRPA_PW_SELF);
      POWERED_DOWN   <= (pw_q == lprpa_pkg::LPRPA_PW_DOWN);
      INT_CLK_EN     <= clk_en_q;
      MODE_READY     <= (modes_q == 2'h3);
      MODE_VALUE     <= mode_q;
      EXT_MODE_VALUE <= emode_q;
    end
  end
endmodule // lprpa_core

// *** test/lprpa_core_chk.sv ***
// lprpa_core_chk: pin assertions for the refresh/power block
// assumes commands spaced so the decode pipeline never overlaps
module lprpa_core_chk #(
  parameter int NUM_BANKS = lprpa_pkg::NUM_BANKS,
  parameter int ROW_BITS  = lprpa_pkg::ROW_BITS
) (
  input wire logic                   MCLK,
  input wire logic                   RST_N,
  input wire logic                   CKE,
  input wire logic                   CS_N,
  input wire logic                   RAS_N,
  input wire logic                   CAS_N,
  input wire logic                   WE_N,
  input wire logic [1:0]             BA,
  input wire logic [ROW_BITS-1:0]    ADDR,
  input wire logic [NUM_BANKS*2-1:0] BANK_STATE,
  input wire logic                   REFRESHING,
  input wire logic                   SELF_REFRESH,
  input wire logic                   POWERED_DOWN,
  input wire logic                   INT_CLK_EN,
  input wire logic                   MODE_READY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic [3:0] cmd;
  logic [1:0] bk1;
  logic       free;
  assign cmd  = {CS_N, RAS_N, CAS_N, WE_N};
  assign bk1  = BANK_STATE[3:2];
  assign free = !POWERED_DOWN && !SELF_REFRESH && !REFRESHING;
  sequence s_wr_ap;
    cmd == lprpa_pkg::CMD_WRITE && ADDR[lprpa_pkg::AP_BIT] && BA == 2'h1 && bk1 == 2'h1
      && CKE && $past(CKE) && free;
  endsequence
  sequence s_recov;
    (bk1 == 2'h2) [*3] ##1 bk1 == 2'h3 ##1 bk1 == 2'h0;
  endsequence
  chk_wr_autoprech: assert property (s_wr_ap |-> ##4 s_recov)
    else $error("auto precharge out of step");
  chk_refresh_start: assert property (cmd == lprpa_pkg::CMD_REFRESH && CKE && $past(CKE)
    && free |-> ##4 REFRESHING)
    else $error("refresh not started");
  chk_refresh_idle: assert property ($fell(REFRESHING) |-> BANK_STATE == 8'h00)
    else $error("bank busy after refresh");
  chk_self_entry: assert property (cmd == lprpa_pkg::CMD_REFRESH && !CKE && $past(CKE)
    && free |-> ##[2:4] SELF_REFRESH)
    else $error("self refresh not entered");
  chk_self_hold: assert property (SELF_REFRESH && !CKE |=> SELF_REFRESH)
    else $error("self refresh left with cke low");
  chk_clk_gate: assert property ($rose(SELF_REFRESH) |-> ##[0:2] !INT_CLK_EN)
    else $error("internal clock not gated");
  chk_pd_entry: assert property ($rose(POWERED_DOWN) |-> !$past(CKE, 3))
    else $error("power down without cke low");
  chk_pd_exit: assert property (POWERED_DOWN |-> !(CKE && $past(CKE) && $past(CKE, 2)
    && $past(CKE, 3) && $past(CKE, 4)))
    else $error("power down held with cke high");
  chk_mode_idle: assert property ($rose(MODE_READY) |-> BANK_STATE == 8'h00)
    else $error("mode set with bank busy");
endmodule // lprpa_core_chk

bind lprpa_core lprpa_core_chk #(.NUM_BANKS(NUM_BANKS), .ROW_BITS(ROW_BITS)) u_chk (
  .MCLK, .RST_N, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .ADDR, .BANK_STATE,
  .REFRESHING, .SELF_REFRESH, .POWERED_DOWN, .INT_CLK_EN, .MODE_READY
);

// *** test/lprpa_ctl_model.sv ***
// lprpa_ctl_model: controller driving commands, cke and address
// assumes a shared MCLK; pins change on its falling edge
module lprpa_ctl_model (
  input  wire logic   MCLK,
  output logic        CKE,
  output logic        CS_N,
  output logic        RAS_N,
  output logic        CAS_N,
  output logic        WE_N,
  output logic [1:0]  BA,
  output logic [13:0] ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    CKE = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = lprpa_pkg::CMD_NOP;
    BA = 2'h0;
    ADDR = 14'h0000;
  end
  // one command, then nop and a spacing gap chosen by the caller
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
    input int gap);
    @(negedge MCLK);
    {CS_N, RAS_N, CAS_N, WE_N} = c;
    BA = b;
    ADDR = a;
    @(negedge MCLK);
    {CS_N, RAS_N, CAS_N, WE_N} = lprpa_pkg::CMD_NOP;
    ADDR = ~a;
    repeat (gap) @(negedge MCLK);
  endtask
  task automatic init();
    repeat (5000) @(negedge MCLK);
    issue(lprpa_pkg::CMD_PRECH, 2'h0, 14'h0400, 6);
    repeat (2) issue(lprpa_pkg::CMD_REFRESH, 2'h0, 14'h0000, 8);
    issue(lprpa_pkg::CMD_MODE, 2'h0, 14'h0032, 6);
    issue(lprpa_pkg::CMD_MODE, 2'h2, 14'h0005, 6);
  endtask
  // nop held on the command pins across each cke change made by set_cke; self_enter drops cke with refresh on the pins
  task automatic set_cke(input logic v, input int hold);
    @(negedge MCLK);
    CKE = v;
    repeat (hold) @(negedge MCLK);
  endtask
  task automatic self_enter();
    @(negedge MCLK);
    CKE = 1'b0;
    {CS_N, RAS_N, CAS_N, WE_N} = lprpa_pkg::CMD_REFRESH;
    @(negedge MCLK);
    {CS_N, RAS_N, CAS_N, WE_N} = lprpa_pkg::CMD_NOP;
  endtask
endmodule // lprpa_ctl_model

// *** test/tb_top.sv ***
// tb_top: directed scenarios for the refresh/power block
// assumes outputs move three cycles after pins are sampled
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, rfr, self_r, pdown, clk_en, mode_rdy;
  logic [1:0]  ba;
  logic [13:0] addr, row, mode_v, ext_v;
  logic [7:0]  bank_st;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic        clk_stop = 1'b0;
  always #20 mclk = clk_stop ? 1'b0 : ~mclk;
  lprpa_ctl_model ctl (.MCLK(mclk), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .BA(ba), .ADDR(addr));
  lprpa_core dut (.MCLK(mclk), .RST_N(rst_n), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .BANK_STATE(bank_st),
    .REFRESH_ROW(row), .REFRESHING(rfr), .SELF_REFRESH(self_r), .POWERED_DOWN(pdown),
    .INT_CLK_EN(clk_en), .MODE_READY(mode_rdy), .MODE_VALUE(mode_v), .EXT_MODE_VALUE(ext_v));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic t_wr_ap();
    int n2;
    int n3;
    n2 = 0;
    n3 = 0;
    ctl.issue(lprpa_pkg::CMD_ACTIVE, 2'h0, 14'h0077, 6);
    ctl.issue(lprpa_pkg::CMD_ACTIVE, 2'h1, 14'h0123, 6);
    ctl.issue(lprpa_pkg::CMD_MODE, 2'h0, 14'h0011, 6);
    check("mode kept", mode_v, 16'h0032);
    ctl.issue(lprpa_pkg::CMD_WRITE, 2'h1, 14'h0000, 6);
    check("write no ap", bank_st[3:2], 16'h0001);
    ctl.issue(lprpa_pkg::CMD_WRITE, 2'h1, 14'h0400, 0);
    repeat (12)
    begin
      @(negedge mclk);
      n2 += (bank_st[3:2] == 2'h2);
      n3 += (bank_st[3:2] == 2'h3);
    end
    check("recovery cycles", 16'(n2), 16'h0003);
    check("precharge cycles", 16'(n3), 16'h0001);
    check("bank1 idle", bank_st[3:2], 16'h0000);
    ctl.issue(lprpa_pkg::CMD_READ, 2'h0, 14'h0000, 6);
    check("bank0 kept", bank_st[1:0], 16'h0001);
  endtask
  task automatic t_refresh();
    logic [13:0] r0;
    int          hit;
    hit = 0;
    ctl.issue(lprpa_pkg::CMD_ACTIVE, 2'h2, 14'h0055, 6);
    r0 = row;
    ctl.issue(lprpa_pkg::CMD_REFRESH, 2'h3, 14'h3FFF, 0);
    repeat (10)
    begin
      @(negedge mclk);
      hit += rfr;
    end
    check("refresh seen", 16'(hit > 0), 16'h0001);
    check("banks idle", bank_st, 16'h0000);
    check("refresh row", row, 16'(r0 + 14'h0001));
  endtask
  task automatic t_pdown();
    ctl.set_cke(1'b0, 6);
    check("power down", pdown, 16'h0001);
    ctl.issue(lprpa_pkg::CMD_ACTIVE, 2'h0, 14'h0001, 6);
    check("active ignored", bank_st, 16'h0000);
    ctl.set_cke(1'b1, 6);
    check("power up", pdown, 16'h0000);
  endtask
  task automatic t_self();
    ctl.self_enter();
    repeat (8) @(negedge mclk);
    check("self refresh", self_r, 16'h0001);
    check("clock gated", clk_en, 16'h0000);
    ctl.set_cke(1'b1, 8);
    check("self exit", self_r, 16'h0000);
    check("clock back", clk_en, 16'h0001);
  endtask
  task automatic t_clk_stop();
    ctl.issue(lprpa_pkg::CMD_ACTIVE, 2'h0, 14'h0077, 6);
    @(negedge mclk);
    clk_stop = 1'b1;
    #410;
    clk_stop = 1'b0;
    ctl.issue(lprpa_pkg::CMD_NOP, 2'h0, 14'h0000, 2);
    check("active held", bank_st, 16'h0001);
    ctl.issue(lprpa_pkg::CMD_READ, 2'h0, 14'h0000, 6);
    ctl.issue(lprpa_pkg::CMD_PRECH, 2'h0, 14'h0000, 6);
    check("bank0 closed", bank_st, 16'h0000);
  endtask
  initial
  begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    check("clock enable", clk_en, 16'h0001);
    check("mode ready", mode_rdy, 16'h0000);
    ctl.init();
    check("mode ready", mode_rdy, 16'h0001);
    check("mode word", mode_v, 16'h0032);
    check("ext mode word", ext_v, 16'h0005);
    t_wr_ap();
    t_refresh();
    t_pdown();
    t_self();
    t_clk_stop();
    summarize();
  end
endmodule // tb_top
